// ==== rtl/sfc_pkg.sv ====
package sfc_pkg;
  // Command codes.
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_MEM_RD = 8'h03;
  localparam logic [7:0] OP_MEM_WR = 8'h02;
  localparam logic [7:0] OP_SEC_ERASE = 8'hd8;
  localparam logic [7:0] OP_ALL_ERASE = 8'hc7;
  localparam logic [7:0] OP_ID_RD = 8'hab;
  // Status bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 4;
  // Array geometry, in bytes.
  localparam logic [19:0] SEC_BIG = 20'h10000;
  localparam logic [19:0] SEC_SMALL = 20'h08000;
  localparam logic [19:0] MEM_BIG = 20'h80000;
  localparam logic [19:0] MEM_SMALL = 20'h20000;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [1:0] DUMMY_BYTES = 2'h3;
  // Status write cycle length in clock cycles.
  localparam logic [19:0] WS_CYCLES = 20'h00010;
  // Identification value; the value is arbitrary.
  localparam logic [7:0] ID_VALUE = 8'h5a;
  // Link clock made by the master.
  localparam int SYS_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_HALF = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  typedef enum logic [2:0] {D_IDLE, D_OP, D_ADDR, D_DUMMY, D_WDATA, D_READ, D_END,
    D_DROP} sfc_dst_t;
  typedef enum logic [1:0] {E_IDLE, E_PROG, E_ERASE, E_WSTAT} sfc_eng_t;
  typedef enum logic [1:0] {S_STAT, S_MEM, S_ID} sfc_src_t;
  typedef enum logic [2:0] {H_IDLE, H_RUN, H_WAITW, H_END, H_GAP} sfc_hst_t;
endpackage

// ==== rtl/sfc_link_if.sv ====
`timescale 1ns/10ps
interface sfc_link_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_cmd_in;
  logic data_out;
  logic data_oe_n;
  logic data_line;
  // Released line reads high, as with a pull-up.
  assign data_line = data_oe_n ? 1'b1 : data_out;
  modport device (
    input serial_clock,
    input chip_select_n,
    input serial_cmd_in,
    output data_out,
    output data_oe_n
  );
  modport master (
    output serial_clock,
    output chip_select_n,
    output serial_cmd_in,
    input data_line
  );
endinterface

// ==== rtl/sfc_device.sv ====
`timescale 1ns/10ps
module sfc_device
  import sfc_pkg::*;
#(
  parameter bit BIG = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  sfc_link_if.device link,
  output logic busy,
  output logic write_latch
);
  logic sclk_s1, sclk_s2, sclk_d, cs_s1, cs_s2, cs_d, din_s1, din_s2;
  logic rise, fall, cs_rise, cs_fall;
  sfc_dst_t st_r, st_nxt;
  sfc_src_t src_r, src_nxt;
  sfc_eng_t eng_r, eng_nxt;
  logic [7:0] op_r, op_nxt, in_r, in_nxt, out_r, out_nxt, byte_in, src_byte, status;
  logic [2:0] bit_r, bit_nxt, obit_r, obit_nxt, bp_r, bp_nxt, ebp_r, ebp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [8:0] wcnt_r, wcnt_nxt;
  logic [7:0] widx_r, widx_nxt, esrc_r, esrc_nxt;
  logic [19:0] eptr_r, eptr_nxt, ecnt_r, ecnt_nxt, amask, ssize, start;
  logic dout_r, dout_nxt, doe_n_r, doe_n_nxt, wel_r, wel_nxt;
  logic pb_we, mem_we, go_prog, go_se, go_all, go_ws, eng_done;
  logic [18:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem [0:MEM_BIG[19:0]-1];
  logic [7:0] pbuf [0:255];

  // The array leaves the factory erased; there is no reset path for it.
  initial begin
    for (int i = 0; i < int'(MEM_BIG); i++) begin
      mem[i] = 8'hff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.serial_clock;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= link.chip_select_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      din_s1 <= link.serial_cmd_in;
      din_s2 <= din_s1;
    end
  end

  assign rise = sclk_s2 & ~sclk_d;
  assign fall = ~sclk_s2 & sclk_d;
  assign cs_rise = cs_s2 & ~cs_d;
  assign cs_fall = ~cs_s2 & cs_d;
  assign amask = (BIG ? MEM_BIG : MEM_SMALL) - 20'h1;
  assign ssize = BIG ? SEC_BIG : SEC_SMALL;
  assign start = addr_r[19:0] & amask & ~(ssize - 20'h1);
  assign busy = (eng_r != E_IDLE);
  assign write_latch = wel_r;
  assign status = {3'h0, bp_r, wel_r, busy};
  assign byte_in = {in_r[6:0], din_s2};
  assign link.data_out = dout_r;
  assign link.data_oe_n = doe_n_r;

  always_comb begin
    unique case (src_r)
      S_STAT: src_byte = status;
      S_MEM: src_byte = mem[addr_r[18:0] & amask[18:0]];
      S_ID: src_byte = ID_VALUE;
      default: src_byte = 8'h00;
    endcase
  end

  // Command side: shifting, decode and the launch of self-timed cycles.
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    in_nxt = in_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    src_nxt = src_r;
    out_nxt = out_r;
    obit_nxt = obit_r;
    dout_nxt = dout_r;
    doe_n_nxt = doe_n_r;
    wel_nxt = wel_r;
    wcnt_nxt = wcnt_r;
    widx_nxt = widx_r;
    pb_we = 1'b0;
    go_prog = 1'b0;
    go_se = 1'b0;
    go_all = 1'b0;
    go_ws = 1'b0;
    if (eng_done) begin
      wel_nxt = 1'b0;
    end
    if (cs_rise || cs_s2) begin
      st_nxt = D_IDLE;
      doe_n_nxt = 1'b1;
      bit_nxt = 3'h0;
      obit_nxt = 3'h0;
      if (cs_rise && bit_r == 3'h0 && st_r == D_END) begin
        case (op_r)
          OP_LATCH_SET: wel_nxt = 1'b1;
          OP_LATCH_CLR: wel_nxt = 1'b0;
          OP_ALL_ERASE: go_all = wel_r;
          OP_SEC_ERASE: go_se = wel_r;
          OP_STAT_WR: go_ws = wel_r;
          default: ;
        endcase
      end
      if (cs_rise && bit_r == 3'h0 && st_r == D_WDATA && wcnt_r != 9'h0) begin
        go_prog = wel_r;
      end
    end else if (cs_fall) begin
      st_nxt = D_OP;
      bit_nxt = 3'h0;
      cnt_nxt = 2'h0;
      wcnt_nxt = 9'h0;
      widx_nxt = 8'h0;
    end else if (rise && st_r != D_IDLE) begin
      in_nxt = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        unique case (st_r)
          D_OP: begin
            op_nxt = byte_in;
            cnt_nxt = 2'h0;
            if (busy && byte_in != OP_STAT_RD) begin
              st_nxt = D_DROP;
            end else begin
              case (byte_in)
                OP_STAT_RD: begin
                  st_nxt = D_READ;
                  src_nxt = S_STAT;
                end
                OP_MEM_RD, OP_MEM_WR, OP_SEC_ERASE: st_nxt = D_ADDR;
                OP_ID_RD: st_nxt = D_DUMMY;
                OP_STAT_WR: st_nxt = D_WDATA;
                OP_LATCH_SET, OP_LATCH_CLR, OP_ALL_ERASE: st_nxt = D_END;
                default: st_nxt = D_DROP;
              endcase
            end
          end
          D_ADDR: begin
            addr_nxt = {addr_r[15:0], byte_in};
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == ADDR_BYTES - 2'h1) begin
              unique case (op_r)
                OP_MEM_RD: begin
                  st_nxt = D_READ;
                  src_nxt = S_MEM;
                end
                OP_MEM_WR: st_nxt = D_WDATA;
                default: st_nxt = D_END;
              endcase
            end
          end
          D_DUMMY: begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == DUMMY_BYTES - 2'h1) begin
              st_nxt = D_READ;
              src_nxt = S_ID;
            end
          end
          D_WDATA: begin
            if (op_r == OP_STAT_WR) begin
              st_nxt = D_END;
            end else begin
              pb_we = 1'b1;
              widx_nxt = widx_r + 8'h1;
              if (wcnt_r != PAGE_BYTES) begin
                wcnt_nxt = wcnt_r + 9'h1;
              end
            end
          end
          D_END: st_nxt = D_DROP;
          D_IDLE, D_READ, D_DROP: ;
        endcase
      end
    end else if (fall && st_r == D_READ) begin
      doe_n_nxt = 1'b0;
      obit_nxt = obit_r + 3'h1;
      if (obit_r == 3'h0) begin
        dout_nxt = src_byte[7];
        out_nxt = {src_byte[6:0], 1'b0};
      end else begin
        dout_nxt = out_r[7];
        out_nxt = {out_r[6:0], 1'b0};
      end
      if (obit_r == 3'h7 && src_r == S_MEM) begin
        addr_nxt = addr_r + 24'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= D_IDLE;
      op_r <= 8'h00;
      in_r <= 8'h00;
      bit_r <= 3'h0;
      cnt_r <= 2'h0;
      addr_r <= 24'h0;
      src_r <= S_STAT;
      out_r <= 8'h00;
      obit_r <= 3'h0;
      dout_r <= 1'b1;
      doe_n_r <= 1'b1;
      wel_r <= 1'b0;
      wcnt_r <= 9'h0;
      widx_r <= 8'h0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      in_r <= in_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      src_r <= src_nxt;
      out_r <= out_nxt;
      obit_r <= obit_nxt;
      dout_r <= dout_nxt;
      doe_n_r <= doe_n_nxt;
      wel_r <= wel_nxt;
      wcnt_r <= wcnt_nxt;
      widx_r <= widx_nxt;
    end
  end

  // Self-timed engine: one byte per clock, so a whole-array erase is long.
  always_comb begin
    eng_nxt = eng_r;
    eptr_nxt = eptr_r;
    ecnt_nxt = ecnt_r;
    esrc_nxt = esrc_r;
    ebp_nxt = ebp_r;
    bp_nxt = bp_r;
    eng_done = 1'b0;
    mem_we = 1'b0;
    mem_wa = eptr_r[18:0];
    mem_wd = 8'hff;
    unique case (eng_r)
      E_IDLE: begin
        if (go_prog) begin
          eng_nxt = E_PROG;
          eptr_nxt = addr_r[19:0] & amask;
          ecnt_nxt = {11'h0, wcnt_r};
          // A full buffer has wrapped, so its oldest byte sits at the write index.
          esrc_nxt = (wcnt_r == PAGE_BYTES) ? widx_r : 8'h0;
        end else if (go_se || go_all) begin
          eng_nxt = E_ERASE;
          eptr_nxt = go_se ? start : 20'h0;
          ecnt_nxt = go_se ? ssize : amask + 20'h1;
        end else if (go_ws) begin
          eng_nxt = E_WSTAT;
          ecnt_nxt = WS_CYCLES;
          ebp_nxt = in_r[ST_BP_HI:ST_BP_LO];
        end
      end
      E_PROG: begin
        mem_we = 1'b1;
        mem_wd = mem[eptr_r[18:0]] & pbuf[esrc_r];
        eptr_nxt = {eptr_r[19:8], eptr_r[7:0] + 8'h1};
        esrc_nxt = esrc_r + 8'h1;
      end
      E_ERASE: begin
        mem_we = 1'b1;
        eptr_nxt = eptr_r + 20'h1;
      end
      E_WSTAT: ;
    endcase
    if (eng_r != E_IDLE) begin
      ecnt_nxt = ecnt_r - 20'h1;
      if (ecnt_r == 20'h1) begin
        eng_nxt = E_IDLE;
        eng_done = 1'b1;
        if (eng_r == E_WSTAT) begin
          bp_nxt = ebp_r;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      eng_r <= E_IDLE;
      eptr_r <= 20'h0;
      ecnt_r <= 20'h0;
      esrc_r <= 8'h0;
      ebp_r <= 3'h0;
      bp_r <= 3'h0;
    end else begin
      eng_r <= eng_nxt;
      eptr_r <= eptr_nxt;
      ecnt_r <= ecnt_nxt;
      esrc_r <= esrc_nxt;
      ebp_r <= ebp_nxt;
      bp_r <= bp_nxt;
    end
  end

  // A plain clocked process: the initial fill above also writes the array, which a
  // process of the always_ff kind would not allow.
  always @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pb_we) begin
      pbuf[widx_r] <= byte_in;
    end
  end
endmodule

// ==== rtl/sfc_master.sv ====
`timescale 1ns/10ps
module sfc_master
  import sfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  sfc_link_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_addr,
  input wire logic [8:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  sfc_hst_t hs_r, hs_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rdat_r, rdat_nxt, nbyte;
  logic [23:0] addr_r, addr_nxt;
  logic [9:0] idx_r, idx_nxt, hdr_r, hdr_nxt, wend_r, wend_nxt, tot_r, tot_nxt, k;
  logic [9:0] na, nd, nw, nr;
  logic [2:0] bit_r, bit_nxt;
  logic [1:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, rval_r, rval_nxt, tick, dl_s1, dl_s2;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dl_s1 <= 1'b1;
      dl_s2 <= 1'b1;
    end else begin
      dl_s1 <= link.data_line;
      dl_s2 <= dl_s1;
    end
  end

  assign tick = (div_r == 2'(LINK_HALF - 1));
  assign k = idx_r + 10'h1;
  assign cmd_ready = (hs_r == H_IDLE);
  assign wr_ready = (hs_r == H_WAITW);
  assign rd_valid = rval_r;
  assign rd_data = rdat_r;
  assign link.serial_clock = sclk_r;
  assign link.chip_select_n = cs_n_r;
  assign link.serial_cmd_in = tx_r[7];

  always_comb begin
    na = 10'h0;
    nd = 10'h0;
    nw = 10'h0;
    nr = 10'h0;
    case (cmd_op)
      OP_MEM_RD: begin
        na = 10'h3;
        nr = {1'b0, cmd_len};
      end
      OP_MEM_WR: begin
        na = 10'h3;
        nw = (cmd_len == 9'h0) ? 10'h1 : {1'b0, cmd_len};
      end
      OP_SEC_ERASE: na = 10'h3;
      OP_ID_RD: begin
        nd = 10'h3;
        nr = {1'b0, cmd_len};
      end
      OP_STAT_RD: nr = {1'b0, cmd_len};
      OP_STAT_WR: nw = 10'h1;
      default: ;
    endcase
  end

  always_comb begin
    if (k == 10'h1) begin
      nbyte = addr_r[23:16];
    end else if (k == 10'h2) begin
      nbyte = addr_r[15:8];
    end else begin
      nbyte = addr_r[7:0];
    end
    if (k >= hdr_r || k > 10'h3) begin
      nbyte = 8'h00;
    end
  end

  always_comb begin
    hs_nxt = hs_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rdat_nxt = rdat_r;
    idx_nxt = idx_r;
    hdr_nxt = hdr_r;
    wend_nxt = wend_r;
    tot_nxt = tot_r;
    bit_nxt = bit_r;
    div_nxt = tick ? 2'h0 : div_r + 2'h1;
    sclk_nxt = sclk_r;
    cs_n_nxt = cs_n_r;
    rval_nxt = 1'b0;
    unique case (hs_r)
      H_IDLE: begin
        div_nxt = 2'h0;
        if (cmd_valid) begin
          hs_nxt = H_RUN;
          addr_nxt = cmd_addr;
          tx_nxt = cmd_op;
          hdr_nxt = 10'h1 + na + nd;
          wend_nxt = 10'h1 + na + nd + nw;
          tot_nxt = 10'h1 + na + nd + nw + nr;
          idx_nxt = 10'h0;
          bit_nxt = 3'h0;
          cs_n_nxt = 1'b0;
          sclk_nxt = 1'b0;
        end
      end
      H_RUN: begin
        if (tick && !sclk_r) begin
          sclk_nxt = 1'b1;
        end else if (tick) begin
          sclk_nxt = 1'b0;
          // Sampling late in the high phase covers the device's output lag.
          rx_nxt = {rx_r[6:0], dl_s2};
          tx_nxt = {tx_r[6:0], 1'b0};
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            idx_nxt = k;
            if (idx_r >= wend_r) begin
              rval_nxt = 1'b1;
              rdat_nxt = {rx_r[6:0], dl_s2};
            end
            if (k == tot_r) begin
              hs_nxt = H_END;
            end else if (k >= hdr_r && k < wend_r) begin
              hs_nxt = H_WAITW;
            end else begin
              tx_nxt = nbyte;
            end
          end
        end
      end
      H_WAITW: begin
        div_nxt = 2'h0;
        if (wr_valid) begin
          tx_nxt = wr_data;
          hs_nxt = H_RUN;
        end
      end
      H_END: begin
        if (tick) begin
          cs_n_nxt = 1'b1;
          hs_nxt = H_GAP;
        end
      end
      H_GAP: begin
        if (tick) begin
          hs_nxt = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hs_r <= H_IDLE;
      addr_r <= 24'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdat_r <= 8'h00;
      idx_r <= 10'h0;
      hdr_r <= 10'h0;
      wend_r <= 10'h0;
      tot_r <= 10'h0;
      bit_r <= 3'h0;
      div_r <= 2'h0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      rval_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      addr_r <= addr_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rdat_r <= rdat_nxt;
      idx_r <= idx_nxt;
      hdr_r <= hdr_nxt;
      wend_r <= wend_nxt;
      tot_r <= tot_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      cs_n_r <= cs_n_nxt;
      rval_r <= rval_nxt;
    end
  end
endmodule

// ==== tb/sfc_monitor.sv ====
`timescale 1ns/10ps
module sfc_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_cmd_in,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic data_line
);
  logic [2:0] bits_r;
  logic [2:0] bits_nxt;
  logic byte_r;
  logic byte_nxt;
  logic sclk_r;
  logic sclk_nxt;
  // Bits are counted modulo eight so that long bursts never saturate the count.
  always_comb begin
    sclk_nxt = serial_clock;
    bits_nxt = bits_r;
    byte_nxt = byte_r;
    if (chip_select_n) begin
      bits_nxt = 3'h0;
      byte_nxt = 1'b0;
    end else if (serial_clock && !sclk_r) begin
      bits_nxt = bits_r + 3'h1;
      byte_nxt = byte_r || (bits_r == 3'h7);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bits_r <= 3'h0;
      byte_r <= 1'b0;
      sclk_r <= 1'b0;
    end else begin
      bits_r <= bits_nxt;
      byte_r <= byte_nxt;
      sclk_r <= sclk_nxt;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  AST_CS_BYTE: assert property ($rose(chip_select_n) |-> bits_r == 3'h0)
    else $error("deselect off a byte boundary");
  AST_OE_START: assert property ($fell(data_oe_n) |-> byte_r && bits_r == 3'h0)
    else $error("output started before a whole command");
  AST_OE_RELEASE: assert property ($rose(chip_select_n) |-> ##[1:5] data_oe_n)
    else $error("output not released after deselect");
  AST_NO_DRIVE: assert property (chip_select_n [*6] |-> data_oe_n && data_line)
    else $error("output driven while deselected");
  AST_OUT_HOLD: assert property ($rose(serial_clock) && !data_oe_n |=> $stable(data_out))
    else $error("output changed after a rising link edge");
  AST_CMD_HOLD: assert property ($rose(serial_clock) |=> $stable(serial_cmd_in))
    else $error("command bit changed after a rising link edge");
  AST_HALF: assert property ($rose(serial_clock) |-> serial_clock [*4])
    else $error("link clock high phase too short");
  AST_CS_SETUP: assert property ($fell(chip_select_n) |-> !serial_clock [*4])
    else $error("link clock rose too soon after select");
  AST_CLK_IDLE: assert property (chip_select_n |-> !serial_clock)
    else $error("link clock moved while deselected");
  cover property ($rose(chip_select_n) && byte_r);
  cover property ($fell(data_oe_n));
  cover property ($rose(chip_select_n) && !data_oe_n);
endmodule

// ==== tb/sfc_bench.sv ====
`timescale 1ns/10ps
module sfc_bench;
  import sfc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h000000;
  logic [8:0] cmd_len = 9'h000;
  logic wr_valid = 1'b0;
  logic wr_ready;
  logic [7:0] wr_data = 8'h00;
  logic rd_valid;
  logic [7:0] rd_data;
  logic busy;
  logic write_latch;
  logic busy2;
  logic latch2;
  logic took = 1'b0;
  logic [7:0] rd_q[$];
  logic [7:0] wr_q[$];
  int errors = 0;
  int cmp_count = 0;
  sfc_link_if link ();
  sfc_link_if link2 ();
  sfc_device #(.BIG(1'b0)) sfc_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link.device), .busy(busy), .write_latch(write_latch));
  // A second device faces a driver that breaks the framing rules on purpose.
  sfc_device #(.BIG(1'b0)) sfc_device_inst2 (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(link2.device), .busy(busy2), .write_latch(latch2));
  sfc_master sfc_master_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data));
  sfc_monitor sfc_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .serial_clock(link.serial_clock), .chip_select_n(link.chip_select_n),
    .serial_cmd_in(link.serial_cmd_in), .data_out(link.data_out),
    .data_oe_n(link.data_oe_n), .data_line(link.data_line));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    took <= wr_valid && wr_ready;
    if (rd_valid === 1'b1) begin
      rd_q.push_back(rd_data);
    end
  end
  always @(negedge sys_clk) begin
    if (took && wr_q.size() > 0) begin
      wr_q.delete(0);
    end
    wr_valid = wr_q.size() > 0;
    wr_data = (wr_q.size() > 0) ? wr_q[0] : 8'h00;
  end
  task automatic stop_test();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] len);
    int n;
    rd_q.delete();
    @(negedge sys_clk);
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      stop_test();
    end
  endtask
  // Polls status until the self-timed cycle is over; an erase needs a few hundred polls.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      run(OP_STAT_RD, 24'h000000, 9'h001);
      n++;
    end while (n < 400 && (rd_q.size() == 0 || rd_q[0][ST_BUSY] !== 1'b0));
    if (rd_q.size() == 0 || rd_q[0][ST_BUSY] !== 1'b0) begin
      errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] d);
    run(OP_LATCH_SET, 24'h000000, 9'h000);
    wr_q.push_back(d);
    run(op, addr, 9'h001);
    wait_idle();
  endtask
  task automatic bang(input logic [31:0] bits, input int n);
    link2.chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link2.serial_cmd_in = bits[i];
      repeat (4) @(negedge sys_clk);
      link2.serial_clock = 1'b1;
      repeat (4) @(negedge sys_clk);
      link2.serial_clock = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    link2.chip_select_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    link2.serial_clock = 1'b0;
    link2.chip_select_n = 1'b1;
    link2.serial_cmd_in = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    run(OP_STAT_RD, 24'h000000, 9'h002);
    chk(rd_q[0], 8'h00);
    chk(rd_q[1], 8'h00);
    run(OP_LATCH_SET, 24'h000000, 9'h000);
    run(OP_STAT_RD, 24'h000000, 9'h001);
    chk(rd_q[0], 8'h02);
    run(OP_LATCH_CLR, 24'h000000, 9'h000);
    run(OP_STAT_RD, 24'h000000, 9'h001);
    chk(rd_q[0], 8'h00);
    run(OP_ID_RD, 24'h000000, 9'h003);
    for (int i = 0; i < 3; i++) chk(rd_q[i], ID_VALUE);
    run(OP_LATCH_SET, 24'h000000, 9'h000);
    wr_q = '{8'ha1, 8'hb2, 8'hc3};
    run(OP_MEM_WR, 24'h0080fe, 9'h003);
    wait_idle();
    chk({7'h00, write_latch}, 8'h00);
    wr(OP_MEM_WR, 24'h007fff, 8'h3c);
    run(OP_MEM_RD, 24'h0080fe, 9'h003);
    chk(rd_q[0], 8'ha1);
    chk(rd_q[1], 8'hb2);
    chk(rd_q[2], 8'hff);
    wr_q.push_back(8'h00);
    run(OP_MEM_WR, 24'h009000, 9'h001);
    run(OP_MEM_RD, 24'h009000, 9'h001);
    chk(rd_q[0], 8'hff);
    run(OP_LATCH_SET, 24'h000000, 9'h000);
    run(OP_SEC_ERASE, 24'h000000, 9'h000);
    chk({7'h00, busy}, 8'h01);
    run(OP_MEM_RD, 24'h0080fe, 9'h001);
    chk(rd_q[0], 8'hff);
    run(OP_LATCH_CLR, 24'h000000, 9'h000);
    run(OP_STAT_RD, 24'h000000, 9'h001);
    chk(rd_q[0], 8'h03);
    wait_idle();
    chk(rd_q[0], 8'h00);
    run(OP_MEM_RD, 24'h007fff, 9'h002);
    chk(rd_q[0], 8'hff);
    chk(rd_q[1], 8'hc3);
    run(OP_LATCH_SET, 24'h000000, 9'h000);
    for (int k = 0; k < 257; k++) wr_q.push_back(k == 256 ? 8'h77 : k[7:0]);
    run(OP_MEM_WR, 24'h00a000, 9'h101);
    wait_idle();
    // The oldest kept byte lands at the start address, the newest at the page end.
    run(OP_MEM_RD, 24'h00a000, 9'h002);
    chk(rd_q[0], 8'h01);
    chk(rd_q[1], 8'h02);
    run(OP_MEM_RD, 24'h00a0ff, 9'h001);
    chk(rd_q[0], 8'h77);
    wr(OP_STAT_WR, 24'h000000, 8'hff);
    chk(rd_q[0], 8'h1c);
    bang({24'h000000, OP_LATCH_SET}, 8);
    chk({7'h00, latch2}, 8'h01);
    bang({24'h000000, OP_LATCH_CLR}, 7);
    chk({7'h00, latch2}, 8'h01);
    bang({OP_MEM_WR, 24'h000100}, 32);
    chk({7'h00, busy2}, 8'h00);
    chk({7'h00, latch2}, 8'h01);
    bang({16'h0000, OP_ALL_ERASE, 8'h00}, 16);
    chk({7'h00, busy2}, 8'h00);
    chk({7'h00, latch2}, 8'h01);
    bang({24'h000000, OP_LATCH_CLR}, 8);
    chk({7'h00, latch2}, 8'h00);
    stop_test();
  end
endmodule
